// ---- design/sbg_pkg.sv ----
// constants for the serial baud generator and mode control block
// assumes a single system clock that also serves as the main oscillator
`default_nettype none

package sbg_pkg;

    // ************************************************************
    // register map: printed offsets are word indices, byte = 4 * index
    // ************************************************************
    localparam int          AXI_AW     = 18;
    localparam logic [15:0] IDX_ASYNC  = 16'hFF70;
    localparam logic [15:0] IDX_SYNC   = 16'hFF72;
    localparam logic [15:0] IDX_BRGC   = 16'hFF73;
    localparam logic [15:0] IDX_STATUS = 16'hFF74;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ************************************************************
    // fields, masks and reset values
    // ************************************************************
    localparam int ASYNC_TXE  = 7;
    localparam int ASYNC_RXE  = 6;
    localparam int SYNC_EN    = 7;
    localparam int SYNC_DIR   = 2;
    localparam int SYNC_CSCK  = 1;
    localparam int SRC_LO     = 4;

    localparam logic [7:0] ASYNC_MASK = 8'hFC;
    localparam logic [7:0] SYNC_MASK  = 8'h86;
    localparam logic [7:0] BRGC_MASK  = 8'hF0;
    localparam logic [7:0] REG_RESET  = 8'h00;

    // ************************************************************
    // source codes and rate constants
    // ************************************************************
    localparam logic [3:0] SRC_MAX_INT = 4'h7;
    localparam logic [3:0] SRC_EXT     = 4'h8;
    localparam int         OS_W        = 4;
    localparam logic [3:0] OS_LAST     = 4'hF;
    localparam int         PRESC_W     = 8;
    localparam int         CLK_HZ      = 125_000_000;

    typedef enum logic [2:0] {
        MODE_STOP  = 3'b001,
        MODE_ASYNC = 3'b010,
        MODE_SYNC  = 3'b100
    } sbg_mode_t;

endpackage

`default_nettype wire

// ---- design/sbg_sync2.sv ----
// two-flop synchroniser for pin inputs
// assumes the inputs are asynchronous to clk_i
`default_nettype none

module sbg_sync2 #(
    parameter int W = 2
) (
    // clock and reset
    input  wire logic         clk_i,
    input  wire logic         arst_n_i,
    // data
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);

    logic [W-1:0] meta_q;

    // the first stage feeds only the second stage
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            meta_q <= '0;
            q_o    <= '0;
        end else begin
            meta_q <= d_i;
            q_o    <= meta_q;
        end
    end

endmodule

`default_nettype wire

// ---- design/sbg_prescaler.sv ----
// power-of-two prescaler: one tick every 2^(code+1) clocks
// assumes code_i is stable except when clear_i restarts the phase
`default_nettype none

module sbg_prescaler #(
    parameter int W  = 8,
    parameter int CW = $clog2(W)
) (
    // clock and reset
    input  wire logic          clk_i,
    input  wire logic          arst_n_i,
    // control
    input  wire logic          en_i,
    input  wire logic          clear_i,
    input  wire logic [CW-1:0] code_i,
    // tick
    output logic               tick_o
);

    logic [W-1:0] cnt_q;
    logic [W-1:0] bit_ok;

    // bits above the selected power do not take part in the match
    for (genvar i = 0; i < W; i++) begin : g_bit
        assign bit_ok[i] = cnt_q[i] | (code_i < CW'(i));
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cnt_q  <= '0;
            tick_o <= 1'b0;
        end else begin
            cnt_q  <= clear_i ? '0 : cnt_q + 1'b1;
            tick_o <= en_i & ~clear_i & (&bit_ok);
        end
    end

endmodule

`default_nettype wire

// ---- design/sbg_top.sv ----
// baud generator and operating mode control of one serial interface
// assumes an AXI4-Lite master on clk_i and pins from outside the domain
//
// How it works
// - the clock select register takes only full byte writes; reset clears it.
// - codes 0 to 7 pick the oscillator divided by 2^n, n = code + 1.
// - code 8 (value 0x80) picks the external baud clock pin.
// - asynchronous internal bit rate is fx / 2^(n+1) / 8.
// - asynchronous external bit rate is the pin clock over sixteen.
// - internal 3-wire shift clock is fx / 2^(n+1).
// - external 3-wire shift clock ignores the clock select register.
// - three modes, stopped, asynchronous and 3-wire, picked by enable bits.
// - stopped mode moves nothing and frees the three pins for port use.
// - sync mode: bit 7 enable, bit 2 first bit, bit 1 clock source.
// - sync mode register resets to zero and accepts byte writes.
// - async mode: bit 7 transmit, bit 6 receive enable; reset clears all.
// - asynchronous transmit and receive run independently, full duplex.
// - a 500 kHz pin clock gives the 31.25 kbps instrument link rate.
//
// The implementer's own choice: the AXI4-Lite slave port.
`default_nettype none

module sbg_top (
    // clock and reset
    input  wire logic                         clk_i,
    input  wire logic                         arst_n_i,
    // axi4-lite write address and data
    input  wire logic [sbg_pkg::AXI_AW-1:0]   s_axi_awaddr_i,
    input  wire logic                         s_axi_awvalid_i,
    output logic                              s_axi_awready_o,
    input  wire logic [31:0]                  s_axi_wdata_i,
    input  wire logic [3:0]                   s_axi_wstrb_i,
    input  wire logic                         s_axi_wvalid_i,
    output logic                              s_axi_wready_o,
    // axi4-lite write response
    output logic [1:0]                        s_axi_bresp_o,
    output logic                              s_axi_bvalid_o,
    input  wire logic                         s_axi_bready_i,
    // axi4-lite read
    input  wire logic [sbg_pkg::AXI_AW-1:0]   s_axi_araddr_i,
    input  wire logic                         s_axi_arvalid_i,
    output logic                              s_axi_arready_o,
    output logic [31:0]                       s_axi_rdata_o,
    output logic [1:0]                        s_axi_rresp_o,
    output logic                              s_axi_rvalid_o,
    input  wire logic                         s_axi_rready_i,
    // pins
    input  wire logic                         ext_baud_clock_pin_i,
    input  wire logic                         sync_shift_clock_pin_i,
    output logic                              sync_shift_clock_pin_o,
    output logic                              sync_shift_clock_pin_oe_n_o,
    // rate ticks towards the serial datapaths
    output logic                              os_tick_o,
    output logic                              baud_tick_o,
    output logic                              shift_clk_o,
    // mode state towards datapaths and port logic
    output logic                              tx_enable_o,
    output logic                              rx_enable_o,
    output logic                              sync_serial_enable_o,
    output logic                              first_bit_lsb_o,
    output logic                              port_pins_free_o
);

    // ************************************************************
    // registers and state
    // ************************************************************
    logic [7:0]               async_mode_control_q;
    logic [7:0]               sync_mode_control_q;
    logic [7:0]               baud_clock_select_q;
    sbg_pkg::sbg_mode_t       mode_q;
    sbg_pkg::sbg_mode_t       mode_d;
    logic [sbg_pkg::OS_W-1:0] os_cnt_q;
    logic                     ext_dly_q;

    logic                     aw_full_q;
    logic                     w_full_q;
    logic [15:0]              aw_idx_q;
    logic [7:0]               w_byte_q;
    logic                     w_lane0_q;
    logic [15:0]              ar_idx;

    // ************************************************************
    // bus decode
    // ************************************************************
    wire wr_fire    = aw_full_q & w_full_q & ~s_axi_bvalid_o;
    wire wr_async   = aw_idx_q == sbg_pkg::IDX_ASYNC;
    wire wr_sync    = aw_idx_q == sbg_pkg::IDX_SYNC;
    wire wr_brgc    = aw_idx_q == sbg_pkg::IDX_BRGC;
    wire wr_status  = aw_idx_q == sbg_pkg::IDX_STATUS;
    wire wr_mapped  = wr_async | wr_sync | wr_brgc | wr_status;
    wire wr_take    = wr_fire & w_lane0_q;
    wire brgc_wr    = wr_take & wr_brgc;

    assign ar_idx   = s_axi_araddr_i[sbg_pkg::AXI_AW-1:2];
    wire ar_fire    = s_axi_arvalid_i & s_axi_arready_o;
    wire rd_async   = ar_idx == sbg_pkg::IDX_ASYNC;
    wire rd_sync    = ar_idx == sbg_pkg::IDX_SYNC;
    wire rd_brgc    = ar_idx == sbg_pkg::IDX_BRGC;
    wire rd_status  = ar_idx == sbg_pkg::IDX_STATUS;
    wire rd_mapped  = rd_async | rd_sync | rd_brgc | rd_status;

    // ************************************************************
    // mode and source decode
    // ************************************************************
    wire tx_on      = async_mode_control_q[sbg_pkg::ASYNC_TXE];
    wire rx_on      = async_mode_control_q[sbg_pkg::ASYNC_RXE];
    wire sync_on    = sync_mode_control_q[sbg_pkg::SYNC_EN];
    wire sync_int   = sync_mode_control_q[sbg_pkg::SYNC_CSCK];
    // mixed enables are prohibited and fall back to stopped
    assign mode_d   = (sync_on & ~tx_on & ~rx_on) ? sbg_pkg::MODE_SYNC :
                      (~sync_on & (tx_on | rx_on)) ? sbg_pkg::MODE_ASYNC :
                      sbg_pkg::MODE_STOP;

    wire [3:0] src_code = baud_clock_select_q[7:sbg_pkg::SRC_LO];
    wire code_int   = src_code <= sbg_pkg::SRC_MAX_INT;
    wire code_ext   = src_code == sbg_pkg::SRC_EXT;
    wire bad_code   = ~code_int & ~code_ext;
    wire is_async   = mode_q == sbg_pkg::MODE_ASYNC;
    wire is_sync    = mode_q == sbg_pkg::MODE_SYNC;
    wire int_shift  = is_sync & sync_int;
    wire ext_shift  = is_sync & ~sync_int;

    // a write restarts the divider phase, which is why writes mid-transfer corrupt it
    wire presc_clr  = brgc_wr | (mode_q == sbg_pkg::MODE_STOP);
    wire presc_en   = code_int & (is_async | int_shift);
    wire presc_tick;

    logic [1:0] pin_s;
    wire ext_s      = pin_s[0];
    wire sck_s      = pin_s[1];
    wire ext_rise   = ext_s & ~ext_dly_q;

    // external pin source counts only in asynchronous mode
    wire async_tick = is_async & ((code_int & presc_tick) |
                                  (code_ext & ext_rise));
    wire int_tick   = int_shift & code_int & presc_tick;
    wire os_clr     = ~is_async | brgc_wr;

    // ************************************************************
    // helpers
    // ************************************************************
    sbg_sync2 #(
        .W        (2)
    ) u_sync (
        .clk_i    (clk_i),
        .arst_n_i (arst_n_i),
        .d_i      ({sync_shift_clock_pin_i, ext_baud_clock_pin_i}),
        .q_o      (pin_s)
    );

    sbg_prescaler #(
        .W        (sbg_pkg::PRESC_W)
    ) u_presc (
        .clk_i    (clk_i),
        .arst_n_i (arst_n_i),
        .en_i     (presc_en),
        .clear_i  (presc_clr),
        .code_i   (src_code[2:0]),
        .tick_o   (presc_tick)
    );

    // ************************************************************
    // axi4-lite write channel
    // ************************************************************
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            aw_full_q       <= 1'b0;
            w_full_q        <= 1'b0;
            aw_idx_q        <= '0;
            w_byte_q        <= '0;
            w_lane0_q       <= 1'b0;
            s_axi_awready_o <= 1'b1;
            s_axi_wready_o  <= 1'b1;
            s_axi_bvalid_o  <= 1'b0;
            s_axi_bresp_o   <= sbg_pkg::RESP_OKAY;
        end else begin
            if (s_axi_awvalid_i & s_axi_awready_o) begin
                aw_full_q       <= 1'b1;
                aw_idx_q        <= s_axi_awaddr_i[sbg_pkg::AXI_AW-1:2];
                s_axi_awready_o <= 1'b0;
            end
            if (s_axi_wvalid_i & s_axi_wready_o) begin
                w_full_q       <= 1'b1;
                w_byte_q       <= s_axi_wdata_i[7:0];
                w_lane0_q      <= s_axi_wstrb_i[0];
                s_axi_wready_o <= 1'b0;
            end
            if (wr_fire) begin
                s_axi_bvalid_o <= 1'b1;
                s_axi_bresp_o  <= wr_mapped ? sbg_pkg::RESP_OKAY : sbg_pkg::RESP_SLVERR;
            end
            if (s_axi_bvalid_o & s_axi_bready_i) begin
                s_axi_bvalid_o  <= 1'b0;
                aw_full_q       <= 1'b0;
                w_full_q        <= 1'b0;
                s_axi_awready_o <= 1'b1;
                s_axi_wready_o  <= 1'b1;
            end
        end
    end

    // ************************************************************
    // mode registers
    // ************************************************************
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            async_mode_control_q <= sbg_pkg::REG_RESET;
            sync_mode_control_q  <= sbg_pkg::REG_RESET;
            baud_clock_select_q  <= sbg_pkg::REG_RESET;
        end else begin
            if (wr_take & wr_async) begin
                async_mode_control_q <= w_byte_q & sbg_pkg::ASYNC_MASK;
            end
            if (wr_take & wr_sync) begin
                sync_mode_control_q <= w_byte_q & sbg_pkg::SYNC_MASK;
            end
            if (brgc_wr) begin
                baud_clock_select_q <= w_byte_q & sbg_pkg::BRGC_MASK;
            end
        end
    end

    // ************************************************************
    // axi4-lite read channel
    // ************************************************************
    wire [7:0] status_byte = {3'h0, bad_code, sync_shift_clock_pin_o, mode_q};
    wire [7:0] rd_byte = rd_async  ? async_mode_control_q :
                         rd_sync   ? sync_mode_control_q :
                         rd_brgc   ? baud_clock_select_q :
                         rd_status ? status_byte : 8'h00;

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            s_axi_arready_o <= 1'b1;
            s_axi_rvalid_o  <= 1'b0;
            s_axi_rdata_o   <= '0;
            s_axi_rresp_o   <= sbg_pkg::RESP_OKAY;
        end else begin
            if (ar_fire) begin
                s_axi_arready_o <= 1'b0;
                s_axi_rvalid_o  <= 1'b1;
                s_axi_rdata_o   <= {24'h000000, rd_byte};
                s_axi_rresp_o   <= rd_mapped ? sbg_pkg::RESP_OKAY : sbg_pkg::RESP_SLVERR;
            end else if (s_axi_rvalid_o & s_axi_rready_i) begin
                s_axi_rvalid_o  <= 1'b0;
                s_axi_arready_o <= 1'b1;
            end
        end
    end

    // ************************************************************
    // rate generation
    // ************************************************************
    wire [sbg_pkg::OS_W-1:0] os_cnt_d = os_clr ? '0 :
                                        async_tick ? os_cnt_q + 1'b1 : os_cnt_q;
    // shift clock idles high and toggles once per source period
    wire shift_d = ~int_shift ? 1'b1 : (int_tick ? ~sync_shift_clock_pin_o :
                                        sync_shift_clock_pin_o);

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ext_dly_q                   <= 1'b0;
            os_cnt_q                    <= '0;
            os_tick_o                   <= 1'b0;
            baud_tick_o                 <= 1'b0;
            sync_shift_clock_pin_o      <= 1'b1;
            sync_shift_clock_pin_oe_n_o <= 1'b1;
            shift_clk_o                 <= 1'b1;
        end else begin
            ext_dly_q   <= ext_s;
            os_cnt_q    <= os_cnt_d;
            os_tick_o   <= async_tick & ~brgc_wr;
            baud_tick_o <= async_tick & ~brgc_wr & (os_cnt_q == sbg_pkg::OS_LAST);
            sync_shift_clock_pin_o      <= shift_d;
            sync_shift_clock_pin_oe_n_o <= ~int_shift;
            shift_clk_o <= ext_shift ? sck_s : shift_d;
        end
    end

    // ************************************************************
    // mode outputs
    // ************************************************************
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            mode_q               <= sbg_pkg::MODE_STOP;
            tx_enable_o          <= 1'b0;
            rx_enable_o          <= 1'b0;
            sync_serial_enable_o <= 1'b0;
            first_bit_lsb_o      <= 1'b0;
            port_pins_free_o     <= 1'b1;
        end else begin
            mode_q               <= mode_d;
            tx_enable_o          <= (mode_d == sbg_pkg::MODE_ASYNC) & tx_on;
            rx_enable_o          <= (mode_d == sbg_pkg::MODE_ASYNC) & rx_on;
            sync_serial_enable_o <= mode_d == sbg_pkg::MODE_SYNC;
            first_bit_lsb_o      <= sync_mode_control_q[sbg_pkg::SYNC_DIR];
            port_pins_free_o     <= mode_d == sbg_pkg::MODE_STOP;
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    logic [sbg_pkg::OS_W-1:0] chk_os_q;
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            chk_os_q <= '0;
        end else begin
            chk_os_q <= (os_clr | baud_tick_o) ? '0 : chk_os_q + 4'(os_tick_o);
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);

    AST_BRGC_LANE: assert property (wr_fire & wr_brgc & ~w_lane0_q |=> $stable(baud_clock_select_q))
        else $error("clock select changed on a write without byte lane 0");
    AST_N3_PERIOD: assert property (disable iff (!arst_n_i || presc_clr || !presc_en)
        presc_tick & presc_en & (src_code == 4'h2) |=> !presc_tick [*7] ##1 presc_tick)
        else $error("n = 3 source tick period is not eight clocks");
    AST_EXT_PATH: assert property (is_async & code_ext & ext_rise & ~brgc_wr |=> os_tick_o)
        else $error("external source does not follow the pin edge");
    AST_BAUD_16: assert property (baud_tick_o |-> os_tick_o && chk_os_q == 4'hF)
        else $error("bit tick not after sixteen source ticks");
    AST_SHIFT_TOGGLE: assert property ($past(int_shift) & int_shift
        & $changed(sync_shift_clock_pin_o) |-> $past(int_tick))
        else $error("shift clock toggled without a source tick");
    AST_EXT_SHIFT: assert property (ext_shift ##1 ext_shift |-> sync_shift_clock_pin_oe_n_o
        && shift_clk_o == $past(sck_s))
        else $error("external shift clock not followed or pin driven");
    AST_STOP_QUIET: assert property ($past(mode_q == sbg_pkg::MODE_STOP) && mode_q ==
        sbg_pkg::MODE_STOP |-> port_pins_free_o && !os_tick_o && !baud_tick_o)
        else $error("stopped mode still ticks or holds the pins");
    AST_MODE_SYNC: assert property (mode_q == sbg_pkg::MODE_SYNC |->
        $past(sync_on) && !$past(tx_on) && !$past(rx_on))
        else $error("3-wire mode entered with wrong enables");
    AST_BAD_CODE: assert property ($past(bad_code) |-> !os_tick_o && !baud_tick_o)
        else $error("prohibited source code still produces ticks");
    AST_BRGC_LOW: assert property (baud_clock_select_q[3:0] == 4'h0)
        else $error("clock select low nibble not zero");

endmodule

`default_nettype wire

// ---- verif/sbg_far_end.sv ----
// far-side clock source: external baud clock pin and 3-wire shift clock pin
// assumes the bench raises run_i only while the link should be clocked
`default_nettype none

module sbg_far_end #(
    parameter int HALF = 40
) (
    input  wire logic run_i,
    output logic      ext_clk_o,
    output logic      sck_o
);
    timeunit 1ns;
    timeprecision 1ns;
    // both clocks start high and stop at the first half period that begins with run_i low
    initial begin
        ext_clk_o = 1'h1;
        sck_o = 1'h1;
        forever begin
            // edges land between system clock edges, never on them
            wait (run_i);
            #(HALF - 3);
            ext_clk_o = ~ext_clk_o;
            sck_o = ~sck_o;
            #3;
        end
    end
endmodule

`default_nettype wire

// ---- verif/tb.sv ----
// self-checking bench for sbg_top: register map, modes and rates
// assumes sbg_top and sbg_pkg are compiled first
`default_nettype none

module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk_i = 1'h0, arst_n_i = 1'h0, run = 1'h0, sp = 1'h1;
    logic [17:0] s_axi_awaddr_i = '0, s_axi_araddr_i = '0;
    logic        s_axi_awvalid_i = '0, s_axi_wvalid_i = '0, s_axi_bready_i = '0;
    logic        s_axi_arvalid_i = '0, s_axi_rready_i = '0;
    logic [31:0] s_axi_wdata_i = '0, s_axi_rdata_o, d;
    logic [3:0]  s_axi_wstrb_i = '0;
    logic [1:0]  s_axi_bresp_o, s_axi_rresp_o, r;
    logic        s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o;
    logic        s_axi_rvalid_o, ext_baud_clock_pin_i, sync_shift_clock_pin_i;
    logic        sync_shift_clock_pin_o, sync_shift_clock_pin_oe_n_o, os_tick_o;
    logic        baud_tick_o, shift_clk_o, tx_enable_o, rx_enable_o;
    logic        sync_serial_enable_o, first_bit_lsb_o, port_pins_free_o;
    int          n_tests = 0, n_errors = 0, bc = 0, bgap = 0, sc = 0, sgap = 0, nos = 0;
    logic [15:0] tix [5] = '{16'hFF72, 16'hFF70, 16'hFF73, 16'hFF73, 16'hFF71};
    logic [7:0]  twd [5] = '{8'h06, 8'hFC, 8'hFF, 8'h37, 8'h55};
    logic [7:0]  trd [5] = '{8'h06, 8'hFC, 8'hF0, 8'h30, 8'h00};
    logic [1:0]  trs [5] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h2};

    sbg_top i_sbg_top (.clk_i, .arst_n_i, .s_axi_awaddr_i, .s_axi_awvalid_i, .s_axi_awready_o,
        .s_axi_wdata_i, .s_axi_wstrb_i, .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bresp_o,
        .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_araddr_i, .s_axi_arvalid_i, .s_axi_arready_o,
        .s_axi_rdata_o, .s_axi_rresp_o, .s_axi_rvalid_o, .s_axi_rready_i, .ext_baud_clock_pin_i,
        .sync_shift_clock_pin_i, .sync_shift_clock_pin_o, .sync_shift_clock_pin_oe_n_o,
        .os_tick_o, .baud_tick_o, .shift_clk_o, .tx_enable_o, .rx_enable_o,
        .sync_serial_enable_o, .first_bit_lsb_o, .port_pins_free_o);
    // the pins are only ever driven from outside, as inputs
    sbg_far_end i_sbg_far_end (.run_i(run), .ext_clk_o(ext_baud_clock_pin_i),
        .sck_o(sync_shift_clock_pin_i));

    initial begin
        forever #4 clk_i = ~clk_i;
    end
    // gaps in clocks between baud ticks and between shift clock edges
    always @(posedge clk_i) begin
        nos <= nos + int'(os_tick_o === 1'h1);
        bc <= (baud_tick_o === 1'h1) ? 1 : bc + 1;
        if (baud_tick_o === 1'h1) bgap <= bc;
        sc <= (shift_clk_o !== sp) ? 1 : sc + 1;
        if (shift_clk_o !== sp) sgap <= sc;
        sp <= shift_clk_o;
    end

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        n_tests++;
        if (s !== e) begin
            n_errors++;
            $display("unexpected %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic wr(input logic [15:0] ix, input logic [7:0] v, input logic [3:0] st = 4'h1);
        @(posedge clk_i);
        s_axi_awaddr_i <= {ix, 2'h0};
        s_axi_wdata_i <= {24'h0, v};
        s_axi_wstrb_i <= st;
        s_axi_awvalid_i <= 1'h1;
        s_axi_wvalid_i <= 1'h1;
        s_axi_bready_i <= 1'h1;
        forever begin
            @(posedge clk_i);
            if (s_axi_awready_o === 1'h1) s_axi_awvalid_i <= 1'h0;
            if (s_axi_wready_o === 1'h1) s_axi_wvalid_i <= 1'h0;
            if (s_axi_bvalid_o === 1'h1) break;
        end
        s_axi_bready_i <= 1'h0;
    endtask
    task automatic rd(input logic [15:0] ix);
        @(posedge clk_i);
        s_axi_araddr_i <= {ix, 2'h0};
        s_axi_arvalid_i <= 1'h1;
        s_axi_rready_i <= 1'h1;
        forever begin
            @(posedge clk_i);
            if (s_axi_arready_o === 1'h1) s_axi_arvalid_i <= 1'h0;
            if (s_axi_rvalid_o === 1'h1) break;
        end
        d = s_axi_rdata_o;
        r = s_axi_rresp_o;
        s_axi_rready_i <= 1'h0;
    endtask
    task automatic close_out;
        $display("tests %0d errors %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    // ************************************************************
    // main sequence
    // ************************************************************
    initial begin
        repeat (2) @(posedge clk_i);
        arst_n_i <= 1'h1;
        chk("pins_free", 1, port_pins_free_o);
        for (int i = 0; i < 3; i++) begin
            rd(tix[i]);
            chk("reset", 0, d);
        end
        for (int i = 0; i < 5; i++) begin
            wr(tix[i], twd[i]);
            rd(tix[i]);
            chk("rdata", trd[i], d);
            chk("rresp", trs[i], r);
        end
        chk("rx_en", 1, rx_enable_o);
        chk("lsb_first", 1, first_bit_lsb_o);
        wr(sbg_pkg::IDX_SYNC, 8'h00);
        wr(sbg_pkg::IDX_BRGC, 8'h10);
        wr(sbg_pkg::IDX_ASYNC, 8'h80);
        repeat (300) @(posedge clk_i);
        chk("tx_en", 1, tx_enable_o);
        chk("rx_en", 0, rx_enable_o);
        chk("pins_free", 0, port_pins_free_o);
        chk("baud_gap", 8 * 2 ** 3, bgap);
        wr(sbg_pkg::IDX_BRGC, 8'h90);
        d = nos;
        repeat (100) @(posedge clk_i);
        chk("os_ticks", d, nos);
        wr(sbg_pkg::IDX_BRGC, 8'h20, 4'h0);
        rd(sbg_pkg::IDX_BRGC);
        chk("brgc", 8'h90, d);
        run <= 1'h1;
        wr(sbg_pkg::IDX_BRGC, 8'h80);
        repeat (600) @(posedge clk_i);
        chk("ext_gap", 16 * 10, bgap);
        wr(sbg_pkg::IDX_ASYNC, 8'h00);
        wr(sbg_pkg::IDX_BRGC, 8'h20);
        wr(sbg_pkg::IDX_SYNC, 8'h80);
        repeat (100) @(posedge clk_i);
        chk("ext_sck", 5, sgap);
        chk("oe_n", 1, sync_shift_clock_pin_oe_n_o);
        chk("sync_en", 1, sync_serial_enable_o);
        run <= 1'h0;
        wr(sbg_pkg::IDX_SYNC, 8'h00);
        wr(sbg_pkg::IDX_SYNC, 8'h82);
        repeat (100) @(posedge clk_i);
        chk("int_sck", 2 ** (3 + 1) / 2, sgap);
        chk("oe_n", 0, sync_shift_clock_pin_oe_n_o);
        wr(sbg_pkg::IDX_SYNC, 8'h00);
        @(posedge clk_i);
        @(posedge clk_i);
        chk("pins_free", 1, port_pins_free_o);
        // second reset in mid-run must bring the clock select back to zero
        arst_n_i <= 1'h0;
        @(posedge clk_i);
        arst_n_i <= 1'h1;
        rd(sbg_pkg::IDX_BRGC);
        chk("brgc_reset", 0, d);
        close_out();
    end
    // the whole sequence needs about 1300 clocks
    initial begin
        repeat (20000) @(posedge clk_i);
        n_errors++;
        close_out();
    end
endmodule

`default_nettype wire
